// [hdl/ssp_defines.vh]
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// ==========================================
// core clock and wait times
`define SSP_CLK_MHZ 25
`define SSP_PAGE_WAIT_US 4500
`define SSP_DATA_WAIT_US 9000
`define SSP_ERASE_WAIT_US 9000
`define SSP_FUSE_WAIT_US 4500
`define SSP_WAIT_W 24
// ==========================================
// instruction bytes
`define SSP_OP_ENABLE 8'hAC
`define SSP_KEY_ENABLE 8'h53
`define SSP_KEY_ERASE 8'h80
`define SSP_OP_POLL 8'hF0
`define SSP_OP_EXT_ADDR 8'h4D
`define SSP_OP_LOAD_HI 8'h48
`define SSP_OP_LOAD_LO 8'h40
`define SSP_OP_PAGE_WR 8'h4C
`define SSP_OP_DATA_WR 8'hC0
`define SSP_OP_DLOAD 8'hC1
`define SSP_OP_DPAGE_WR 8'hC2
`define SSP_OP_READ_HI 8'h28
`define SSP_OP_READ_LO 8'h20
`define SSP_OP_DATA_RD 8'hA0
// ==========================================
// values and positions
`define SSP_ERASED_BYTE 8'hFF
`define SSP_IDLE_BYTE 8'h00
`define SSP_PEND_BIT 0
`define SSP_BIT_LAST 3'h7
`define SSP_IDX_READ 2'h2
`define SSP_IDX_LAST 2'h3
`endif

// [hdl/ssp_prog_port.v]
`timescale 1ns/1ps
`include "ssp_defines.vh"
// Contract
// - arrays program over sck/mosi/miso only while the reset pin is held low
// - program and erase refused until the enable instruction has completed
// - mosi sampled on rising sck, miso changed on falling sck
// - enable is AC 53 00 00; 53 echoes on miso during the third byte
// - chip erase AC 80 sets both arrays entirely to FF
// - data-array writes erase the location themselves first
// - opcode 4D loads extended address from the third byte
// - 48 and 40 load page high and low byte at word in third byte
// - page write commits buffer to page given by upper address bits
// - C0 writes one data byte; next waits 9.0 ms without polling
// - C1 loads data page by 2 lsb; C2 commits only loaded bytes
// - 28, 20 read program high/low bytes, A0 reads data array
// - reset pin high leaves programming mode for normal operation
// - poll answer lsb is 1 while an operation is pending, else 0
// - opcode 4C writes program page, address in bytes two and three
module ssp_prog_port #(
  parameter PROG_AW = 14,
  parameter PAGE_AW = 6,
  parameter DATA_AW = 10,
  parameter DPAGE_AW = 2,
  parameter [`SSP_WAIT_W-1:0] PAGE_WAIT_CYC = `SSP_PAGE_WAIT_US * `SSP_CLK_MHZ,
  parameter [`SSP_WAIT_W-1:0] DATA_WAIT_CYC = `SSP_DATA_WAIT_US * `SSP_CLK_MHZ,
  parameter [`SSP_WAIT_W-1:0] ERASE_WAIT_CYC = `SSP_ERASE_WAIT_US * `SSP_CLK_MHZ
) (
  input wire clock_i,
  input wire reset_i,
  input wire prog_reset_n_i,
  input wire sck_i,
  input wire mosi_i,
  output wire miso_o,
  output wire miso_oe_o,
  output wire prog_enabled_o,
  output wire busy_o,
  output wire normal_run_o
);
  localparam PROG_DEPTH = 1 << PROG_AW;
  localparam PAGE_WORDS = 1 << PAGE_AW;
  localparam DATA_DEPTH = 1 << DATA_AW;
  localparam DPAGE_BYTES = 1 << DPAGE_AW;
  localparam SW_IDLE = 4'b0001;
  localparam SW_ERASE = 4'b0010;
  localparam SW_PPAGE = 4'b0100;
  localparam SW_DPAGE = 4'b1000;
  localparam [PROG_AW-1:0] CNT_ERASE_END = PROG_DEPTH - 1;
  localparam [PROG_AW-1:0] CNT_PAGE_END = PAGE_WORDS - 1;
  localparam [PROG_AW-1:0] CNT_DPAGE_END = DPAGE_BYTES - 1;

  // ==========================================
  // storage
  reg [15:0] prog_mem [0:PROG_DEPTH-1];
  reg [7:0] data_mem [0:DATA_DEPTH-1];
  reg [15:0] page_buf [0:PAGE_WORDS-1];
  reg [7:0] dpage_buf [0:DPAGE_BYTES-1];

  // ==========================================
  // state
  reg rstn_s1_reg;
  reg rstn_s2_reg;
  reg in_prog_reg;
  reg enabled_reg;
  reg [1:0] idx_reg;
  reg [7:0] op_reg;
  reg [7:0] b1_reg;
  reg [7:0] b2_reg;
  reg [7:0] ext_reg;
  reg [7:0] resp_reg;
  reg [7:0] resp_next;
  reg [3:0] sw_state_reg;
  reg [PROG_AW-1:0] sw_cnt_reg;
  reg [PROG_AW-PAGE_AW-1:0] page_reg;
  reg [DATA_AW-DPAGE_AW-1:0] dpage_reg;
  reg [DPAGE_BYTES-1:0] dmask_reg;
  reg tmr_start;
  reg [`SSP_WAIT_W-1:0] tmr_load;

  wire rx_valid;
  wire [7:0] rx_byte;
  wire tmr_busy;
  wire busy;
  wire last;
  wire run_ok;
  wire [23:0] rd_addr;
  wire [23:0] wr_addr;
  wire [15:0] rd_word;
  wire [7:0] rd_data;
  wire [PROG_AW-1:0] wr_word;
  wire [DATA_AW-1:0] wr_daddr;
  wire do_enable;
  wire do_erase;
  wire do_ext;
  wire do_lo;
  wire do_hi;
  wire do_pwr;
  wire do_dwr;
  wire do_dld;
  wire do_dpwr;
  wire [PAGE_AW-1:0] sw_word;
  wire [DPAGE_AW-1:0] sw_byte;

  function is_op;
    input [7:0] op;
    input [7:0] code;
    begin
      is_op = (op == code);
    end
  endfunction

  // ==========================================
  // serial link
  ssp_shifter u_shifter (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .clear_i(!in_prog_reg),
    .sck_i(sck_i),
    .mosi_i(mosi_i),
    .tx_byte_i(resp_reg),
    .miso_o(miso_o),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte)
  );

  ssp_wait_timer #(
    .W(`SSP_WAIT_W)
  ) u_timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(tmr_start),
    .load_i(tmr_load),
    .busy_o(tmr_busy)
  );

  assign busy = tmr_busy || (sw_state_reg != SW_IDLE);
  assign busy_o = busy;
  assign miso_oe_o = in_prog_reg;
  assign prog_enabled_o = enabled_reg;
  assign normal_run_o = !in_prog_reg;

  // ==========================================
  // programming mode follows the reset pin
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rstn_s1_reg <= 1'b1;
      rstn_s2_reg <= 1'b1;
      in_prog_reg <= 1'b0;
    end
    else
    begin
      rstn_s1_reg <= prog_reset_n_i;
      rstn_s2_reg <= rstn_s1_reg;
      in_prog_reg <= !rstn_s2_reg;
    end
  end

  // ==========================================
  // instruction decode, on the fourth byte
  assign last = rx_valid && (idx_reg == `SSP_IDX_LAST);
  // writes while busy are dropped: they would corrupt the running cycle
  assign run_ok = last && enabled_reg && !busy;
  assign do_enable = last && is_op(op_reg, `SSP_OP_ENABLE)
    && is_op(b1_reg, `SSP_KEY_ENABLE);
  assign do_erase = run_ok && is_op(op_reg, `SSP_OP_ENABLE)
    && is_op(b1_reg, `SSP_KEY_ERASE);
  assign do_ext = run_ok && is_op(op_reg, `SSP_OP_EXT_ADDR);
  assign do_lo = run_ok && is_op(op_reg, `SSP_OP_LOAD_LO);
  assign do_hi = run_ok && is_op(op_reg, `SSP_OP_LOAD_HI);
  assign do_pwr = run_ok && is_op(op_reg, `SSP_OP_PAGE_WR);
  assign do_dwr = run_ok && is_op(op_reg, `SSP_OP_DATA_WR);
  assign do_dld = run_ok && is_op(op_reg, `SSP_OP_DLOAD);
  assign do_dpwr = run_ok && is_op(op_reg, `SSP_OP_DPAGE_WR);

  // read address uses the third byte as it arrives
  assign rd_addr = {ext_reg, b1_reg, rx_byte};
  assign wr_addr = {ext_reg, b1_reg, b2_reg};
  assign rd_word = prog_mem[rd_addr[PROG_AW-1:0]];
  assign rd_data = data_mem[rd_addr[DATA_AW-1:0]];
  assign wr_word = wr_addr[PROG_AW-1:0];
  assign wr_daddr = wr_addr[DATA_AW-1:0];
  assign sw_word = sw_cnt_reg[PAGE_AW-1:0];
  assign sw_byte = sw_cnt_reg[DPAGE_AW-1:0];

  always @*
  begin
    resp_next = rx_byte;
    if (idx_reg == `SSP_IDX_LAST)
      resp_next = `SSP_IDLE_BYTE;
    else if (idx_reg == `SSP_IDX_READ)
    begin
      // answer for the fourth byte
      if (is_op(op_reg, `SSP_OP_POLL))
      begin
        resp_next = `SSP_IDLE_BYTE;
        resp_next[`SSP_PEND_BIT] = busy;
      end
      else if (enabled_reg && is_op(op_reg, `SSP_OP_READ_LO))
        resp_next = rd_word[7:0];
      else if (enabled_reg && is_op(op_reg, `SSP_OP_READ_HI))
        resp_next = rd_word[15:8];
      else if (enabled_reg && is_op(op_reg, `SSP_OP_DATA_RD))
        resp_next = rd_data;
    end
  end

  always @*
  begin
    tmr_start = do_erase || do_pwr || do_dwr || do_dpwr;
    tmr_load = DATA_WAIT_CYC;
    if (do_erase)
      tmr_load = ERASE_WAIT_CYC;
    else if (do_pwr)
      tmr_load = PAGE_WAIT_CYC;
  end

  always @(posedge clock_i)
  begin
    // the synced pin drops enable together with the mode, never a cycle after it
    if (reset_i || !in_prog_reg || rstn_s2_reg)
    begin
      enabled_reg <= 1'b0;
      idx_reg <= 2'h0;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      ext_reg <= 8'h00;
      resp_reg <= 8'h00;
    end
    else if (rx_valid)
    begin
      idx_reg <= idx_reg + 2'h1;
      resp_reg <= resp_next;
      case (idx_reg)
        2'h0: op_reg <= rx_byte;
        2'h1: b1_reg <= rx_byte;
        2'h2: b2_reg <= rx_byte;
        default: op_reg <= op_reg;
      endcase
      if (do_enable)
        enabled_reg <= 1'b1;
      if (do_ext)
        ext_reg <= b2_reg;
    end
  end

  // ==========================================
  // sweep engine for erase and page commits
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sw_state_reg <= SW_IDLE;
      sw_cnt_reg <= {PROG_AW{1'b0}};
      page_reg <= {(PROG_AW-PAGE_AW){1'b0}};
      dpage_reg <= {(DATA_AW-DPAGE_AW){1'b0}};
      dmask_reg <= {DPAGE_BYTES{1'b0}};
    end
    else
    begin
      if (do_dld)
        dmask_reg[b2_reg[DPAGE_AW-1:0]] <= 1'b1;
      case (sw_state_reg)
        SW_IDLE:
        begin
          sw_cnt_reg <= {PROG_AW{1'b0}};
          if (do_erase)
            sw_state_reg <= SW_ERASE;
          else if (do_pwr)
          begin
            page_reg <= wr_word[PROG_AW-1:PAGE_AW];
            sw_state_reg <= SW_PPAGE;
          end
          else if (do_dpwr)
          begin
            dpage_reg <= wr_daddr[DATA_AW-1:DPAGE_AW];
            sw_state_reg <= SW_DPAGE;
          end
        end
        SW_ERASE:
        begin
          sw_cnt_reg <= sw_cnt_reg + {{(PROG_AW-1){1'b0}}, 1'b1};
          if (sw_cnt_reg == CNT_ERASE_END)
            sw_state_reg <= SW_IDLE;
        end
        SW_PPAGE:
        begin
          sw_cnt_reg <= sw_cnt_reg + {{(PROG_AW-1){1'b0}}, 1'b1};
          if (sw_cnt_reg == CNT_PAGE_END)
            sw_state_reg <= SW_IDLE;
        end
        SW_DPAGE:
        begin
          sw_cnt_reg <= sw_cnt_reg + {{(PROG_AW-1){1'b0}}, 1'b1};
          if (sw_cnt_reg == CNT_DPAGE_END)
          begin
            dmask_reg <= {DPAGE_BYTES{1'b0}};
            sw_state_reg <= SW_IDLE;
          end
        end
        default: sw_state_reg <= SW_IDLE;
      endcase
    end
  end

  // ==========================================
  // array writes; arrays carry no reset, like real cells
  always @(posedge clock_i)
  begin
    if (sw_state_reg == SW_ERASE)
      prog_mem[sw_cnt_reg] <= {`SSP_ERASED_BYTE, `SSP_ERASED_BYTE};
    else if (sw_state_reg == SW_PPAGE)
      prog_mem[{page_reg, sw_word}] <= page_buf[sw_word];
  end

  always @(posedge clock_i)
  begin
    // chip erase blanks the buffer too, so words never loaded commit as erased
    if (sw_state_reg == SW_PPAGE || sw_state_reg == SW_ERASE)
      page_buf[sw_word] <= {`SSP_ERASED_BYTE, `SSP_ERASED_BYTE};
    else if (do_lo)
      page_buf[b2_reg[PAGE_AW-1:0]][7:0] <= rx_byte;
    else if (do_hi)
      page_buf[b2_reg[PAGE_AW-1:0]][15:8] <= rx_byte;
  end

  always @(posedge clock_i)
  begin
    if (do_dld)
      dpage_buf[b2_reg[DPAGE_AW-1:0]] <= rx_byte;
  end

  always @(posedge clock_i)
  begin
    // a plain overwrite stands in for the built-in erase-then-write
    if (sw_state_reg == SW_ERASE)
    begin
      if (sw_cnt_reg < DATA_DEPTH)
        data_mem[sw_cnt_reg[DATA_AW-1:0]] <= `SSP_ERASED_BYTE;
    end
    else if (sw_state_reg == SW_DPAGE)
    begin
      if (dmask_reg[sw_byte])
        data_mem[{dpage_reg, sw_byte}] <= dpage_buf[sw_byte];
    end
    else if (do_dwr)
      data_mem[wr_daddr] <= rx_byte;
  end
endmodule // ssp_prog_port

// [hdl/ssp_shifter.v]
`timescale 1ns/1ps
`include "ssp_defines.vh"
// ==========================================
// serial byte shifter, sck sampled by the core clock
module ssp_shifter (
  input wire clock_i,
  input wire reset_i,
  input wire clear_i,
  input wire sck_i,
  input wire mosi_i,
  input wire [7:0] tx_byte_i,
  output wire miso_o,
  output reg rx_valid_o,
  output reg [7:0] rx_byte_o
);
  reg sck_s1_reg;
  reg sck_s2_reg;
  reg sck_s3_reg;
  reg mosi_s1_reg;
  reg mosi_s2_reg;
  reg [2:0] bit_cnt_reg;
  reg [6:0] rx_reg;
  reg [7:0] tx_reg;
  wire rise;
  wire fall;

  // edges are found on the second stage against a third, never on the first
  assign rise = sck_s2_reg && !sck_s3_reg;
  assign fall = !sck_s2_reg && sck_s3_reg;
  assign miso_o = tx_reg[7];

  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end
    else
    begin
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      mosi_s1_reg <= mosi_i;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  always @(posedge clock_i)
  begin
    if (reset_i || clear_i)
    begin
      bit_cnt_reg <= 3'h0;
      rx_reg <= 7'h00;
      tx_reg <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (rise)
      begin
        // msb first, sampled on the rising sck edge
        rx_reg <= {rx_reg[5:0], mosi_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == `SSP_BIT_LAST)
        begin
          rx_valid_o <= 1'b1;
          rx_byte_o <= {rx_reg, mosi_s2_reg};
        end
      end
      if (fall)
      begin
        // miso moves only on falling edges; new byte loads after a boundary
        if (bit_cnt_reg == 3'h0)
          tx_reg <= tx_byte_i;
        else
          tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
endmodule // ssp_shifter

// [hdl/ssp_wait_timer.v]
`timescale 1ns/1ps
`include "ssp_defines.vh"
// ==========================================
// self-timed write delay
module ssp_wait_timer #(
  parameter W = `SSP_WAIT_W
) (
  input wire clock_i,
  input wire reset_i,
  input wire start_i,
  input wire [W-1:0] load_i,
  output wire busy_o
);
  reg [W-1:0] count_reg;

  assign busy_o = (count_reg != {W{1'b0}});

  always @(posedge clock_i)
  begin
    if (reset_i)
      count_reg <= {W{1'b0}};
    else if (start_i)
      count_reg <= load_i;
    else if (busy_o)
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
  end
endmodule // ssp_wait_timer

// [tb/ssp_isp_programmer.sv]
`timescale 1ns/1ps
// ==========================================
// programmer model: spi mode 0 master, msb first
module ssp_isp_programmer (
  input wire miso_i,
  input wire miso_oe_i,
  output reg sck_o,
  output reg mosi_o
);
  integer k;
  initial
  begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end
  // 160 ns phases are four core clocks, above the three-clock floor
  task xfer(input [31:0] cmd, output [31:0] resp);
  begin
    #7;
    for (k = 31; k >= 0; k = k - 1)
    begin
      #80 mosi_o = cmd[k];
      #80 sck_o = 1'b1;
      #150 resp[k] = miso_oe_i ? miso_i : ~miso_i;
      #10 sck_o = 1'b0;
    end
    // released line: no pull, so show the inverse rather than a stale bit
    mosi_o = ~mosi_o;
  end
  endtask
endmodule // ssp_isp_programmer

// [tb/ssp_port_checker.sv]
`timescale 1ns/1ps
// ==========================================
// port checker
module ssp_port_checker #(
  parameter PROG_AW = 14,
  parameter ERASE_WAIT_CYC = 200
) (
  input wire clock_i,
  input wire reset_i,
  input wire prog_reset_n_i,
  input wire sck_i,
  input wire mosi_i,
  input wire miso_o,
  input wire miso_oe_o,
  input wire prog_enabled_o,
  input wire busy_o,
  input wire normal_run_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // sweep and timer may overlap, so their sum is a safe ceiling
  localparam int LIM = (1 << PROG_AW) + ERASE_WAIT_CYC + 16;
  reg [31:0] busy_cnt;
  always @(posedge clock_i)
    busy_cnt <= (reset_i || !busy_o) ? 32'h0 : busy_cnt + 32'h1;
  sequence s_pin_low;
    (!prog_reset_n_i) [*5];
  endsequence
  sequence s_pin_high;
    prog_reset_n_i [*5];
  endsequence
  sequence s_sck_low;
    !$past(sck_i, 3) && !$past(sck_i, 2);
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=>
    normal_run_o && !miso_oe_o && !prog_enabled_o && !busy_o)
    else $error("outputs not idle after reset");
  a_mode_entry: assert property (s_pin_low |-> miso_oe_o && !normal_run_o)
    else $error("programming mode not entered");
  a_mode_exit: assert property (s_pin_high |-> normal_run_o && !prog_enabled_o)
    else $error("programming mode not left");
  a_oe_mode: assert property (miso_oe_o == !normal_run_o)
    else $error("miso drive disagrees with mode");
  a_enable_mode: assert property (prog_enabled_o |-> miso_oe_o)
    else $error("enabled outside programming mode");
  a_enable_entry: assert property ($rose(prog_enabled_o) |-> $past(miso_oe_o))
    else $error("enable rose outside mode");
  a_miso_fall: assert property (
    miso_oe_o && $past(miso_oe_o) && $changed(miso_o) |-> s_sck_low)
    else $error("miso changed away from falling sck");
  a_busy_enable: assert property ($rose(busy_o) |-> prog_enabled_o)
    else $error("operation started before enable");
  a_busy_min: assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("pending flag dropped early");
  a_busy_bound: assert property (busy_cnt <= LIM)
    else $error("pending flag stuck");
endmodule // ssp_port_checker
bind ssp_prog_port ssp_port_checker #(
  .PROG_AW(PROG_AW),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC)
) ssp_port_checker_i (
  .clock_i(clock_i), .reset_i(reset_i), .prog_reset_n_i(prog_reset_n_i),
  .sck_i(sck_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .prog_enabled_o(prog_enabled_o), .busy_o(busy_o), .normal_run_o(normal_run_o)
);

// [tb/test_ssp_prog_port.sv]
`timescale 1ns/1ps
// ==========================================
// bench for the serial programming port
module test_ssp_prog_port;
  reg clock_i = 1'b0;
  reg reset_i = 1'b1;
  reg prog_reset_n_i = 1'b0;
  wire sck, mosi, miso, miso_oe, enabled, busy, normal_run;
  integer errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer seed = 32'hF40A;
  integer i;
  integer j;
  reg [31:0] rnd, resp;
  reg [7:0] r, pg, d1, d2;
  reg [9:0] a;
  reg [7:0] lo [0:3];
  reg [7:0] hi [0:3];
  always #20 clock_i = ~clock_i;
  ssp_prog_port #(
    .PAGE_WAIT_CYC(24'hC8),
    .DATA_WAIT_CYC(24'hC8),
    .ERASE_WAIT_CYC(24'hC8)
  ) ssp_prog_port_i (
    .clock_i(clock_i), .reset_i(reset_i), .prog_reset_n_i(prog_reset_n_i),
    .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .prog_enabled_o(enabled), .busy_o(busy), .normal_run_o(normal_run)
  );
  ssp_isp_programmer ssp_isp_programmer_i (
    .miso_i(miso), .miso_oe_i(miso_oe), .sck_o(sck), .mosi_o(mosi)
  );
  function automatic [7:0] rb(input [7:0] m);
    rnd = $random(seed);
    rb = rnd[7:0] & m;
  endfunction
  // word offsets 0, 21, 42 and 63 reach both ends of the page
  function [5:0] w(input [1:0] k);
    w = {k, k, k};
  endfunction
  function [7:0] dexp(input [1:0] k);
    dexp = (k == 2'h0) ? d1 : (k == 2'h1) ? lo[0] : (k == 2'h3) ? lo[1] : 8'hFF;
  endfunction
  task check(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // the wait lets the end-of-instruction action land before any check
  task send(input [7:0] b1, input [7:0] b2, input [7:0] b3, input [7:0] b4);
  begin
    @(negedge clock_i);
    ssp_isp_programmer_i.xfer({b1, b2, b3, b4}, resp);
    r = resp[7:0];
    repeat (4) @(negedge clock_i);
  end
  endtask
  task enable;
  begin
    send(8'hAC, 8'h53, 8'h00, 8'h00);
    check({resp[15:8], enabled}, 9'h0A7);
    if (resp[15:8] !== 8'h53)
    begin
      set_pin(1'b1);
      set_pin(1'b0);
      send(8'hAC, 8'h53, 8'h00, 8'h00);
    end
  end
  endtask
  // poll instead of a blind wait; bounded so a stuck flag cannot hang the run
  task poll_idle;
  begin
    r = 8'h01;
    for (j = 0; j < 100 && r !== 8'h00; j = j + 1)
      send(8'hF0, 8'h00, 8'h00, 8'h00);
  end
  endtask
  task set_pin(input v);
  begin
    @(negedge clock_i);
    prog_reset_n_i = v;
    repeat (10) @(negedge clock_i);
  end
  endtask
  task wrap_up;
  begin
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  always @(posedge clock_i)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      errors = errors + 1;
      wrap_up;
    end
  end
  initial
  begin
    repeat (20) @(negedge clock_i);
    check({normal_run, miso_oe, enabled, busy}, 4'h8);
    reset_i = 1'b0;
    // power-up wait scaled down like the write waits
    repeat (10) @(negedge clock_i);
    check({normal_run, miso_oe}, 2'h1);
    enable;
    send(8'hAC, 8'h80, 8'h00, 8'h00);
    send(8'hF0, 8'h00, 8'h00, 8'h00);
    check(r, 8'h01);
    poll_idle;
    check({r, busy}, 9'h000);
    for (i = 0; i < 3; i = i + 1)
    begin
      send(i[0] ? 8'h28 : 8'h20, rb(8'h3F), rb(8'hFF), 8'h00);
      check(r, 8'hFF);
      send(8'hA0, rb(8'h03), rb(8'hFF), 8'h00);
      check(r, 8'hFF);
    end
    // ==========================================
    // program page: low byte first at each word
    pg = rb(8'hFF);
    for (i = 0; i < 4; i = i + 1)
    begin
      lo[i] = rb(8'hFF);
      hi[i] = rb(8'hFF);
      send(8'h40, 8'h00, {2'h0, w(i[1:0])}, lo[i]);
      send(8'h48, 8'h00, {2'h0, w(i[1:0])}, hi[i]);
    end
    send(8'h4C, {2'h0, pg[7:2]}, {pg[1:0], 6'h00}, 8'h00);
    poll_idle;
    check({r, busy}, 9'h000);
    for (i = 0; i < 4; i = i + 1)
    begin
      send(8'h20, {2'h0, pg[7:2]}, {pg[1:0], w(i[1:0])}, 8'h00);
      check(r, lo[i]);
      send(8'h28, {2'h0, pg[7:2]}, {pg[1:0], w(i[1:0])}, 8'h00);
      check(r, hi[i]);
    end
    send(8'h20, {2'h0, pg[7:2]}, {pg[1:0], 6'h01}, 8'h00);
    check(r, 8'hFF);
    // ==========================================
    // data bytes: complement forces a real erase before the write
    rnd = $random(seed);
    a = rnd[9:0];
    d1 = rb(8'h7F);
    d2 = ~d1;
    send(8'hC0, {6'h00, a[9:8]}, a[7:0], d1);
    check(busy, 1'b1);
    poll_idle;
    send(8'hC0, {6'h00, a[9:8]}, a[7:0], d2);
    send(8'hA0, {6'h00, a[9:8]}, a[7:0], 8'h00);
    check(r, d2);
    pg = ~a[9:2];
    send(8'hC0, {6'h00, pg[7:6]}, {pg[5:0], 2'h0}, d1);
    poll_idle;
    send(8'hC1, 8'h00, 8'h01, lo[0]);
    send(8'hC1, 8'h00, 8'h03, lo[1]);
    send(8'hC2, {6'h00, pg[7:6]}, {pg[5:0], 2'h0}, 8'h00);
    poll_idle;
    for (i = 0; i < 4; i = i + 1)
    begin
      send(8'hA0, {6'h00, pg[7:6]}, {pg[5:0], i[1:0]}, 8'h00);
      check(r, dexp(i[1:0]));
    end
    // ==========================================
    // leave and re-enter: writes refused until enabled again
    set_pin(1'b1);
    check({normal_run, miso_oe, enabled}, 3'h4);
    set_pin(1'b0);
    send(8'hC0, {6'h00, a[9:8]}, a[7:0], d1);
    check(busy, 1'b0);
    enable;
    send(8'hA0, {6'h00, a[9:8]}, a[7:0], 8'h00);
    check(r, d2);
    wrap_up;
  end
endmodule // test_ssp_prog_port
